// >>> serial_config_port.sv
`timescale 1ns/1ps
// Behaviour
// - Default port is three wires: clock, active-low select, one two-way data line.
// - Select high puts both data line and serial output line in high impedance.
// - In three-wire mode the serial output line never drives.
// - Config register bit 7 moves read data to the serial output line.
// - In four-wire mode the output line drives only during read data bits.
// - Every transfer opens with an eight-bit header, data follows without gap.
// - Header top bit one means read, zero means write.
// - Next two header bits give the byte count, one to four.
// - Low five header bits give the register address.
// - Config bit 6 selects least significant bit first; reset value zero.
// - Most-significant-first: header names last register, address decrements per byte.
// - Least-significant-first: header names first register, address increments per byte.
// - Header bits are sampled on rising serial clock edges after select falls.
// - Write data bits are captured on rising edges of eight following cycles.
// - Byte transfer with address step repeats until the counted bytes are moved.
// - Read data bits are driven on falling edges of eight following cycles.
// - In four-wire reads the two-way data line stays in high impedance.
module serial_config_port import serial_config_pkg::*; #(
  parameter int DEPTH = REG_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_output_line,
  output logic serial_output_line_oe,
  output logic cfg_four_wire,
  output logic cfg_lsb_first,
  output logic reg_wr_stb,
  output logic [ADDR_W-1:0] reg_wr_addr,
  output logic [DATA_W-1:0] reg_wr_data
);
  // Control bundles to the byte shifter and the register bank
  shift_if sif();
  mem_if mif();

  // Sequencer state, each register except sclk_d_reg beside its next value
  port_state_t state_reg;
  port_state_t state_next;
  logic sclk_d_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_next;
  logic [1:0] bytes_left_reg;
  logic [1:0] bytes_left_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic need_load_reg;
  logic need_load_next;
  logic rd_cfg_reg;
  logic rd_cfg_next;
  logic [DATA_W-1:0] cfg_reg;
  logic [DATA_W-1:0] cfg_next;
  logic sdio_out_reg;
  logic sdio_out_next;
  logic sdio_oe_reg;
  logic sdio_oe_next;
  logic sol_reg;
  logic sol_next;
  logic sol_oe_reg;
  logic sol_oe_next;
  logic wr_stb_reg;
  logic wr_stb_next;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [ADDR_W-1:0] wr_addr_next;
  logic [DATA_W-1:0] wr_data_reg;
  logic [DATA_W-1:0] wr_data_next;

  // Helpers decoded from registered state and the pins
  logic sclk_rise;
  logic sclk_fall;
  logic four_wire;
  logic lsb_first;
  logic [ADDR_W-1:0] addr_stepped;
  logic [DATA_W-1:0] rd_byte;
  logic out_bit;

  // One shift register serves header, write data and read data alike,
  // since the port never receives and sends in the same bit slot
  byte_shifter u_shifter (
    .clk(clk),
    .srst(srst),
    .clk_en(clk_en),
    .sif(sif)
  );

  // Bank read data are registered, so every fetch is issued at least a clk
  // before the falling serial clock edge that needs the byte
  reg_bank #(.DEPTH(DEPTH)) u_bank (
    .clk(clk),
    .clk_en(clk_en),
    .mif(mif)
  );

  // Pins are synchronous to clk, so a one-cycle delayed copy finds the edges;
  // the serial clock must stay at each level for at least one clk cycle
  assign sclk_rise = sclk & ~sclk_d_reg;
  assign sclk_fall = ~sclk & sclk_d_reg;

  assign four_wire = cfg_reg[CFG_FOUR_WIRE_BIT];
  assign lsb_first = cfg_reg[CFG_LSB_FIRST_BIT];

  // Next register of a burst: down for MSB-first, up for LSB-first
  assign addr_stepped = lsb_first ? (addr_reg + ADDR_STEP) : (addr_reg - ADDR_STEP);

  // The config register lives here, not in the bank, so it steers the port directly
  assign rd_byte = rd_cfg_reg ? cfg_reg : mif.rdata;

  // Both header and data use the same bit order
  assign sif.lsb_first = lsb_first;
  assign sif.load_data = rd_byte;

  // Sequencer next state, shifter control and register bank access
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    bytes_left_next = bytes_left_reg;
    addr_next = addr_reg;
    need_load_next = need_load_reg;
    rd_cfg_next = rd_cfg_reg;
    cfg_next = cfg_reg;
    sdio_out_next = sdio_out_reg;
    sdio_oe_next = sdio_oe_reg;
    sol_next = sol_reg;
    sol_oe_next = sol_oe_reg;
    wr_stb_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    // No shift, no bank access unless a serial clock edge asks for one
    sif.op_load = 1'b0;
    sif.op_shift = 1'b0;
    sif.bit_in = sdio_in;
    mif.we = 1'b0;
    mif.waddr = addr_reg;
    mif.wdata = sif.in_full;
    mif.re = 1'b0;
    mif.raddr = addr_stepped;
    out_bit = sif.pick_cur;
    if (port_select_n) begin
      // A deselect aborts whatever is in flight; a partial write byte is lost
      // and the bank is left untouched by it; bytes completed before the cut stay written
      state_next = ST_IDLE;
      bit_cnt_next = '0;
      need_load_next = 1'b0;
      sdio_oe_next = 1'b0;
      sol_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_HEADER: begin
          // Bit count is already zero here, so the first rise is header bit one
          state_next = ST_HEADER;
          if (sclk_rise) begin
            sif.op_shift = 1'b1;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == LAST_BIT) begin
              // Header complete, data bytes follow with no gap
              bytes_left_next = sif.in_full[HDR_CNT_MSB:HDR_CNT_LSB];
              addr_next = sif.in_full[HDR_ADDR_MSB:HDR_ADDR_LSB];
              if (sif.in_full[HDR_DIR_BIT]) begin
                state_next = ST_READ;
                // Fetch the first byte now; its leading bit leaves at the next fall
                need_load_next = 1'b1;
                mif.re = 1'b1;
                mif.raddr = sif.in_full[HDR_ADDR_MSB:HDR_ADDR_LSB];
                rd_cfg_next = (sif.in_full[HDR_ADDR_MSB:HDR_ADDR_LSB] == CFG_ADDR);
              end else begin
                state_next = ST_WRITE;
              end
            end
          end
        end
        ST_WRITE: begin
          if (sclk_rise) begin
            sif.op_shift = 1'b1;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == LAST_BIT) begin
              // Undefined bits are stored as sent; the host keeps them zero.
              // Config writes skip the bank so a new mode steers the next byte.
              if (addr_reg == CFG_ADDR) begin
                cfg_next = sif.in_full;
              end else begin
                mif.we = 1'b1;
              end
              wr_stb_next = 1'b1;
              wr_addr_next = addr_reg;
              wr_data_next = sif.in_full;
              if (bytes_left_reg == LAST_BYTE) begin
                state_next = ST_DONE;
              end else begin
                bytes_left_next = bytes_left_reg - BYTE_STEP;
                addr_next = addr_stepped;
              end
            end
          end
        end
        ST_READ: begin
          if (sclk_fall) begin
            // A load sends the leading bit of a fresh byte; other falls send the
            // bit that the previous fall left at the front of the shifter
            if (need_load_reg) begin
              sif.op_load = 1'b1;
              out_bit = sif.pick_load;
              need_load_next = 1'b0;
            end else begin
              sif.op_shift = 1'b1;
              sif.bit_in = 1'b0;
            end
            // Only one of the two pins drives, chosen by the port mode
            sdio_out_next = out_bit;
            sol_next = out_bit;
            sdio_oe_next = ~four_wire;
            sol_oe_next = four_wire;
          end else if (sclk_rise) begin
            // Rises only count bits; the data line is not sampled during a read
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == LAST_BIT) begin
              if (bytes_left_reg == LAST_BYTE) begin
                state_next = ST_DONE;
              end else begin
                // Fetch the next byte now; it is needed at the following fall
                bytes_left_next = bytes_left_reg - BYTE_STEP;
                addr_next = addr_stepped;
                mif.re = 1'b1;
                rd_cfg_next = (addr_stepped == CFG_ADDR);
                need_load_next = 1'b1;
              end
            end
          end
        end
        ST_DONE: begin
          // Extra clocks after the counted bytes are ignored
          if (sclk_fall) begin
            sdio_oe_next = 1'b0;
            sol_oe_next = 1'b0;
          end
        end
        default: begin
          // Only reachable through an upset; drop to ST_IDLE, which enters ST_HEADER on the next clock without waiting for a new frame
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // All port state, frozen while clk_en is low
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      sclk_d_reg <= 1'b0;
      bit_cnt_reg <= '0;
      bytes_left_reg <= '0;
      addr_reg <= '0;
      need_load_reg <= 1'b0;
      rd_cfg_reg <= 1'b0;
      cfg_reg <= CFG_RESET;
      sdio_out_reg <= 1'b0;
      sdio_oe_reg <= 1'b0;
      sol_reg <= 1'b0;
      sol_oe_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      sclk_d_reg <= sclk;
      bit_cnt_reg <= bit_cnt_next;
      bytes_left_reg <= bytes_left_next;
      addr_reg <= addr_next;
      need_load_reg <= need_load_next;
      rd_cfg_reg <= rd_cfg_next;
      cfg_reg <= cfg_next;
      sdio_out_reg <= sdio_out_next;
      sdio_oe_reg <= sdio_oe_next;
      sol_reg <= sol_next;
      sol_oe_reg <= sol_oe_next;
      wr_stb_reg <= wr_stb_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // Every output is a register bit; nothing is gated after the flops, so the
  // pins cannot glitch while the sequencer decodes
  assign sdio_out = sdio_out_reg;
  assign sdio_oe = sdio_oe_reg;
  assign serial_output_line = sol_reg;
  assign serial_output_line_oe = sol_oe_reg;

  // Mode bits are shown as they stand, for the device's other logic
  assign cfg_four_wire = cfg_reg[CFG_FOUR_WIRE_BIT];
  assign cfg_lsb_first = cfg_reg[CFG_LSB_FIRST_BIT];

  // One pulse per stored byte; address and data hold until the next one
  assign reg_wr_stb = wr_stb_reg;
  assign reg_wr_addr = wr_addr_reg;
  assign reg_wr_data = wr_data_reg;
endmodule

// >>> serial_config_pkg.sv
package serial_config_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int REG_DEPTH = 32;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 5'h00;
  localparam int CFG_FOUR_WIRE_BIT = 7;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
  localparam int HDR_DIR_BIT = 7;
  localparam int HDR_CNT_MSB = 6;
  localparam int HDR_CNT_LSB = 5;
  localparam int HDR_ADDR_MSB = 4;
  localparam int HDR_ADDR_LSB = 0;
  localparam logic [1:0] LAST_BYTE = 2'h0;
  localparam logic [1:0] BYTE_STEP = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 5'h01;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HEADER = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_READ = 5'b01000,
    ST_DONE = 5'b10000
  } port_state_t;
endpackage

// >>> serial_port_links.sv
`timescale 1ns/1ps
// Control bundle between the port sequencer and its byte shifter
interface shift_if;
  import serial_config_pkg::*;
  logic op_load;
  logic op_shift;
  logic bit_in;
  logic lsb_first;
  logic [DATA_W-1:0] load_data;
  logic [DATA_W-1:0] in_full;
  logic pick_load;
  logic pick_cur;
  modport ctrl(output op_load, output op_shift, output bit_in, output lsb_first,
               output load_data, input in_full, input pick_load, input pick_cur);
  modport shifter(input op_load, input op_shift, input bit_in, input lsb_first,
                  input load_data, output in_full, output pick_load, output pick_cur);
endinterface

// Write and registered-read port of the register bank
interface mem_if;
  import serial_config_pkg::*;
  logic we;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic re;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  modport ctrl(output we, output waddr, output wdata, output re, output raddr,
               input rdata);
  modport mem(input we, input waddr, input wdata, input re, input raddr,
              output rdata);
endinterface

// >>> byte_shifter.sv
`timescale 1ns/1ps
module byte_shifter import serial_config_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  shift_if.shifter sif
);
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] data_next;

  // Shift towards the end that leaves the wire first
  function automatic logic [DATA_W-1:0] shift_one(input logic [DATA_W-1:0] v,
                                                   input logic b, input logic lsb);
    shift_one = lsb ? {b, v[DATA_W-1:1]} : {v[DATA_W-2:0], b};
  endfunction

  function automatic logic pick(input logic [DATA_W-1:0] v, input logic lsb);
    pick = lsb ? v[0] : v[DATA_W-1];
  endfunction

  // Completed byte includes the bit arriving this cycle
  assign sif.in_full = shift_one(data_reg, sif.bit_in, sif.lsb_first);
  assign sif.pick_load = pick(sif.load_data, sif.lsb_first);
  assign sif.pick_cur = pick(data_reg, sif.lsb_first); // Front bit left by the previous fall

  // Load already drops the bit that goes out with the load itself
  always_comb begin
    data_next = data_reg;
    if (sif.op_load) begin
      data_next = shift_one(sif.load_data, 1'b0, sif.lsb_first);
    end else if (sif.op_shift) begin
      data_next = sif.in_full;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      data_reg <= '0;
    end else if (clk_en) begin
      data_reg <= data_next;
    end
  end
endmodule

// >>> reg_bank.sv
`timescale 1ns/1ps
module reg_bank import serial_config_pkg::*; #(
  parameter int DEPTH = REG_DEPTH
) (
  input wire logic clk,
  input wire logic clk_en,
  mem_if.mem mif
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rdata_reg;

  // Contents are not reset; software is expected to program what it uses
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (mif.we) begin
        mem[mif.waddr] <= mif.wdata;
      end
      if (mif.re) begin
        rdata_reg <= mem[mif.raddr];
      end
    end
  end

  assign mif.rdata = rdata_reg;
endmodule

// >>> serial_port_monitor.sv
`timescale 1ns/1ps
module serial_port_monitor import serial_config_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_output_line,
  input wire logic serial_output_line_oe,
  input wire logic cfg_four_wire,
  input wire logic cfg_lsb_first,
  input wire logic reg_wr_stb,
  input wire logic [ADDR_W-1:0] reg_wr_addr,
  input wire logic [DATA_W-1:0] reg_wr_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Output enables are registered, so a released select floats the lines one clock later
  sel_float_a: assert property ($past(port_select_n) |-> !sdio_oe && !serial_output_line_oe)
    else $error("line driven while deselected");
  three_wire_a: assert property (!cfg_four_wire |-> !serial_output_line_oe)
    else $error("output line driven in three-wire mode");
  sdio_quiet_a: assert property (cfg_four_wire |-> !sdio_oe)
    else $error("data line driven in four-wire mode");
  one_driver_a: assert property (!(sdio_oe && serial_output_line_oe))
    else $error("both lines driven");
  wr_pulse_a: assert property (reg_wr_stb |=> !reg_wr_stb)
    else $error("write strobe longer than one clock");
  cfg_load_a: assert property (reg_wr_stb && reg_wr_addr == CFG_ADDR |->
    cfg_four_wire == reg_wr_data[7] && cfg_lsb_first == reg_wr_data[6])
    else $error("config bits not loaded");
  cfg_hold_a: assert property (!$past(srst) && !(reg_wr_stb && reg_wr_addr == CFG_ADDR) |->
    $stable({cfg_four_wire, cfg_lsb_first})) else $error("config changed without write");
  // Read data may only move while the serial clock is low
  rd_edge_a: assert property (sdio_oe && $changed(sdio_out) ||
    serial_output_line_oe && $changed(serial_output_line) |-> !sclk)
    else $error("read data changed off a falling edge");
  wr_framed_a: assert property (reg_wr_stb |-> !$past(port_select_n))
    else $error("write outside a selected frame");
  cover property (reg_wr_stb && reg_wr_addr == CFG_ADDR);
  cover property ($rose(sdio_oe));
  cover property ($rose(serial_output_line_oe));
endmodule

bind serial_config_port serial_port_monitor mon_u (.clk, .srst, .sclk, .port_select_n,
  .sdio_out, .sdio_oe, .serial_output_line, .serial_output_line_oe, .cfg_four_wire,
  .cfg_lsb_first, .reg_wr_stb, .reg_wr_addr, .reg_wr_data);

// >>> cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic clk,
  output logic sclk,
  output logic port_select_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_output_line,
  input wire logic serial_output_line_oe
);
  logic host_d = 1'b0;
  logic host_en = 1'b0;
  logic four = 1'b0;
  // A released line toggles each clock so a stale level never reads as data
  always @(posedge clk) if (!host_en) host_d <= ~host_d;
  assign sdio_in = sdio_oe ? sdio_out : host_d;
  initial begin
    sclk = 1'b0;
    port_select_n = 1'b1;
  end
  // One serial clock period, two system clocks per level; sample after the rise
  task automatic bit_cyc(input logic b, input logic drv, output logic r);
    host_en = drv;
    if (drv) host_d = b;
    sclk = 1'b0;
    repeat (2) @(posedge clk);
    #1 sclk = 1'b1;
    @(posedge clk);
    #1 r = four ? (serial_output_line_oe ? serial_output_line : 1'bx)
                : (sdio_oe ? sdio_out : 1'bx);
    @(posedge clk);
    #1;
  endtask
  // Header then bytes with no gap; stop cuts the frame after that many data bits
  task automatic xfer(input bit rd, input bit [1:0] cnt, input bit [4:0] a, input bit lsb,
                      input bit fw, input bit [31:0] wd, input int stop,
                      output logic [31:0] q);
    logic [7:0] h;
    logic r;
    int bi;
    h = {rd, cnt, a};
    four = fw;
    q = 'x;
    port_select_n = 1'b0;
    for (int i = 0; i < 8; i++) bit_cyc(h[lsb ? i : 7 - i], 1'b1, r);
    for (int k = 0; k < 8 * (cnt + 1) && k != stop; k++) begin
      bi = 8 * (k / 8) + (lsb ? k % 8 : 7 - k % 8);
      bit_cyc(wd[bi], !rd || fw, r);
      q[bi] = r;
    end
    port_select_n = 1'b1;
    host_en = 1'b0;
    @(posedge clk);
    #1 sclk = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

// >>> serial_config_port_tb_top.sv
`timescale 1ns/1ps
`define CMP(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module serial_config_port_tb_top import serial_config_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic sclk, port_select_n, sdio_in, sdio_out, sdio_oe;
  logic serial_output_line, serial_output_line_oe, cfg_four_wire, cfg_lsb_first, reg_wr_stb;
  logic [ADDR_W-1:0] reg_wr_addr;
  logic [DATA_W-1:0] reg_wr_data;
  logic [12:0] wq[$];
  int bad_count = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  serial_config_port dut_u (.clk, .srst, .clk_en, .sclk, .port_select_n, .sdio_in,
    .sdio_out, .sdio_oe, .serial_output_line, .serial_output_line_oe, .cfg_four_wire,
    .cfg_lsb_first, .reg_wr_stb, .reg_wr_addr, .reg_wr_data);
  cfg_host_model host_u (.clk, .sclk, .port_select_n, .sdio_in, .sdio_out, .sdio_oe,
    .serial_output_line, .serial_output_line_oe);
  // Log every written byte as {address, data}
  always @(posedge clk) if (reg_wr_stb === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
  function automatic logic [4:0] addr_at(input logic [4:0] a, input int j, input bit lsb);
    return lsb ? a + 5'(j) : a - 5'(j);
  endfunction
  task automatic conclude();
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  initial begin
    logic [31:0] q, wd;
    logic [7:0] mem [32];
    bit lsb, fw;
    bit [1:0] cnt;
    logic [4:0] b, a;
    void'($urandom(32'h01002B54));
    lsb = 0;
    fw = 0;
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    `CMP({cfg_four_wire, cfg_lsb_first}, 2'h0)
    host_u.xfer(1, 0, CFG_ADDR, 0, 0, 0, -1, q);
    `CMP(q[7:0], CFG_RESET)
    for (int t = 0; t < 24; t++) begin
      // Every six trials step through the four mode and order combinations
      if (t % 6 == 0) begin
        host_u.xfer(0, 0, CFG_ADDR, lsb, fw, {24'h0, 2'(t / 6), 6'h00}, -1, q);
        {fw, lsb} = 2'(t / 6);
        `CMP({cfg_four_wire, cfg_lsb_first}, {fw, lsb})
        host_u.xfer(1, 0, CFG_ADDR, lsb, fw, 0, -1, q);
        `CMP(q[7:0], {fw, lsb, 6'h00})
      end
      // Trial 1 is the corner: four bytes reaching the top address
      cnt = t == 1 ? 2'h3 : 2'($urandom % 4);
      b = t == 1 ? 5'h1C : 5'(1 + $urandom % (31 - cnt));
      a = lsb ? b : b + 5'(cnt);
      wd = $urandom;
      wq.delete();
      host_u.xfer(0, cnt, a, lsb, fw, wd, -1, q);
      `CMP(wq.size(), cnt + 1)
      for (int j = 0; j <= cnt; j++) begin
        `CMP(wq[j], {addr_at(a, j, lsb), wd[8*j+:8]})
        mem[addr_at(a, j, lsb)] = wd[8*j+:8];
      end
      host_u.xfer(1, cnt, a, lsb, fw, 0, -1, q);
      for (int j = 0; j <= cnt; j++) `CMP(q[8*j+:8], mem[addr_at(a, j, lsb)])
    end
    // A frame cut mid-byte writes nothing; the next frame starts clean
    wq.delete();
    host_u.xfer(0, 0, 5'h05, lsb, fw, 32'hA5, 4, q);
    `CMP(wq.size(), 0)
    host_u.xfer(0, 0, 5'h05, lsb, fw, 32'h3C, -1, q);
    `CMP(wq[0], {5'h05, 8'h3C})
    // With the clock enable low a whole frame leaves no trace
    clk_en = 1'b0;
    host_u.xfer(0, 0, 5'h06, lsb, fw, 32'h5A, -1, q);
    clk_en = 1'b1;
    `CMP(wq.size(), 1)
    // A reset in mid-run brings back three-wire, MSB-first operation
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    `CMP({cfg_four_wire, cfg_lsb_first}, 2'h0)
    host_u.xfer(1, 0, CFG_ADDR, 0, 0, 0, -1, q);
    `CMP(q[7:0], CFG_RESET)
    conclude();
  end
endmodule
